// [design/hcs_host_regs.sv]
`include "hcs_cfg.svh"
`default_nettype none
// Summary of operation
// RULE_01: Command field decodes 001 as standby or stop, 011 as start.
// RULE_02: Host changes operating state only by writing a command code; a soft reset write to the reset register also returns it to initial.
// RULE_03: Acceptance of a command depends on the current processing state.
// RULE_04: An accepted command moves the device to the named state.
// RULE_05: Status register reports 000 initial, 001 standby, 011 encoding.
// RULE_06: An illegal command leaves state and status code unchanged.
// RULE_07: In initial state only standby is accepted, moving to standby.
// RULE_08: In standby only start is accepted, moving to encoding.
// RULE_09: While encoding only stop is accepted; others are rejected.
// RULE_10: Offsets 02h to 1Fh are a firmware-defined parameter window.
// RULE_11: On start the core reads parameters and runs while start stands.
// RULE_12: Codes other than 001 and 011 are reserved and never move state.
// RULE_13: Stop while encoding returns to standby with status 001.
module hcs_host_regs
  import hcs_pkg::*;
#(
  parameter int PAR_DEPTH = 30,
  parameter int EVT_W = `HCS_EVT_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [5:0] cpuParAddr,
  output logic [7:0] cpuParData,
  output logic encodeRun,
  output logic startPulse,
  output logic [7:0] transferMode,
  output logic [19:0] srcAddr,
  output logic [16:0] dstAddr,
  output logic [18:0] xferCount,
  output logic icpuInt,
  output logic [`HCS_ROM_W-1:0] romSelect,
  output logic isreqPol,
  output logic osvldPol,
  output logic cpuResetHold,
  input wire logic [EVT_W-1:0] dmaEvtSet,
  output logic dmaIrq,
  input wire logic [7:0] xferDataIn,
  output logic [7:0] xferDataOut,
  output logic xferDataWr,
  output logic xferDataRd
);
  // ****************************************
  // Decode helpers
  // ****************************************
  // Parameter window test, shared by write, read and core port
  function automatic logic inWindow(input logic [5:0] a);
    inWindow = (a >= `HCS_OFF_PAR_LO) && (a <= `HCS_OFF_PAR_HI);
  endfunction

  // Window index; only meaningful when inWindow holds
  function automatic logic [4:0] winIdx(input logic [5:0] a);
    logic [5:0] d;
    d = a - `HCS_OFF_PAR_LO;
    winIdx = d[4:0];
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  hcs_cmd_if cmdIf ();
  logic [`HCS_CMD_W-1:0] cmdReg_q;
  logic [7:0] parMem_q [PAR_DEPTH];
  logic [7:0] xMode_q;
  logic [`HCS_SRC_H_W-1:0] srcHi_q;
  logic [7:0] srcMid_q;
  logic [7:0] srcLo_q;
  logic dstHi_q;
  logic [7:0] dstMid_q;
  logic [7:0] dstLo_q;
  logic [`HCS_CNT_H_W-1:0] cntHi_q;
  logic [7:0] cntMid_q;
  logic [7:0] cntLo_q;
  logic icpu_q;
  logic [`HCS_ROM_W-1:0] rom_q;
  logic [`HCS_POL_W-1:0] pol_q;
  logic nbr_q;
  logic [7:0] tdOut_q;
  logic tdWr_q;
  logic tdRd_q;
  logic [7:0] rdData_q;
  logic [7:0] rdData_d;
  logic rdValid_q;
  logic [7:0] cpuPar_q;
  logic [EVT_W-1:0] evtFlags;
  logic [EVT_W-1:0] evtMask;
  logic allClr;
  logic wrWin;

  // Soft reset from the reset register, acts on the write edge
  assign allClr = regWrEn && regAddr == `HCS_OFF_RST && regWrData[`HCS_RST_ALL_BIT];
  assign wrWin = regWrEn && inWindow(regAddr);

  // ****************************************
  // Command path
  // ****************************************
  // A write to the command register or a soft reset is the only way into the state machine
  // RULE_02: command write strobe
  assign cmdIf.cmdWrite = regWrEn && regAddr == `HCS_OFF_CMD;
  assign cmdIf.cmdCode = regWrData[`HCS_CMD_W-1:0];
  assign cmdIf.softClr = allClr;

  // Command register reads back what the host last wrote, or zero after a soft reset
  // RULE_01: three-bit command field
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmdReg_q <= '0;
    end else if (allClr) begin
      cmdReg_q <= '0;
    end else if (cmdIf.cmdWrite) begin
      cmdReg_q <= cmdIf.cmdCode;
    end
  end

  // Legality and transitions live in the state machine
  // RULE_09: only stop while encoding
  hcs_cmd_fsm u_fsm (
    .clock(clock),
    .rst(rst),
    .cmdIf(cmdIf.fsm)
  );

  // Core keeps running for as long as the encoding state stands
  // RULE_11: run level and start pulse
  assign encodeRun = cmdIf.state == HCS_ST_ENC;
  assign startPulse = cmdIf.startPulse;

  // ****************************************
  // Parameter window
  // ****************************************
  // Plain storage; meaning is given by whatever firmware runs
  // RULE_10: firmware parameter window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PAR_DEPTH; i++) begin
        parMem_q[i] <= `HCS_REG_RST;
      end
    end else if (wrWin) begin
      parMem_q[winIdx(regAddr)] <= regWrData;
    end
  end

  // Core-side read port, registered; out-of-window index reads zero
  // RULE_11: parameter fetch port
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpuPar_q <= `HCS_REG_RST;
    end else if (inWindow(cpuParAddr)) begin
      cpuPar_q <= parMem_q[winIdx(cpuParAddr)];
    end else begin
      cpuPar_q <= `HCS_REG_RST;
    end
  end

  // ****************************************
  // Transfer setup registers
  // ****************************************
  // Mode, address and count bytes; reserved bits are never stored
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xMode_q <= `HCS_REG_RST;
      srcHi_q <= '0;
      srcMid_q <= `HCS_REG_RST;
      srcLo_q <= `HCS_REG_RST;
      dstHi_q <= 1'b0;
      dstMid_q <= `HCS_REG_RST;
      dstLo_q <= `HCS_REG_RST;
      cntHi_q <= '0;
      cntMid_q <= `HCS_REG_RST;
      cntLo_q <= `HCS_REG_RST;
    end else if (allClr) begin
      xMode_q <= `HCS_REG_RST;
      srcHi_q <= '0;
      srcMid_q <= `HCS_REG_RST;
      srcLo_q <= `HCS_REG_RST;
      dstHi_q <= 1'b0;
      dstMid_q <= `HCS_REG_RST;
      dstLo_q <= `HCS_REG_RST;
      cntHi_q <= '0;
      cntMid_q <= `HCS_REG_RST;
      cntLo_q <= `HCS_REG_RST;
    end else if (regWrEn) begin
      unique case (regAddr)
        `HCS_OFF_XMODE: xMode_q <= regWrData & `HCS_XMODE_MASK;
        `HCS_OFF_SRC_H: srcHi_q <= regWrData[`HCS_SRC_H_W-1:0];
        `HCS_OFF_SRC_M: srcMid_q <= regWrData;
        `HCS_OFF_SRC_L: srcLo_q <= regWrData;
        `HCS_OFF_DST_H: dstHi_q <= regWrData[0];
        `HCS_OFF_DST_M: dstMid_q <= regWrData;
        `HCS_OFF_DST_L: dstLo_q <= regWrData;
        `HCS_OFF_CNT_H: cntHi_q <= regWrData[`HCS_CNT_H_W-1:0];
        `HCS_OFF_CNT_M: cntMid_q <= regWrData;
        `HCS_OFF_CNT_L: cntLo_q <= regWrData;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Miscellaneous control registers
  // ****************************************
  // Core interrupt, boot source, stream polarity, core reset hold
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      icpu_q <= 1'b0;
      rom_q <= '0;
      pol_q <= '0;
      nbr_q <= 1'b0;
    end else if (allClr) begin
      icpu_q <= 1'b0;
      rom_q <= '0;
      pol_q <= '0;
      nbr_q <= 1'b0;
    end else if (regWrEn) begin
      unique case (regAddr)
        `HCS_OFF_ICPU: icpu_q <= regWrData[0];
        `HCS_OFF_ROM: rom_q <= regWrData[`HCS_ROM_W-1:0];
        `HCS_OFF_POL: pol_q <= regWrData[`HCS_POL_W-1:0];
        `HCS_OFF_RST: nbr_q <= regWrData[`HCS_RST_NBR_BIT];
        default: ;
      endcase
    end
  end

  // Transfer event flags and their mask
  hcs_evt_flags #(
    .EVT_W(EVT_W)
  ) u_evt (
    .clock(clock),
    .rst(rst),
    .softClr(allClr),
    .evtSet(dmaEvtSet),
    .flagWr(regWrEn && regAddr == `HCS_OFF_EFLAG),
    .maskWr(regWrEn && regAddr == `HCS_OFF_EMASK),
    .wrData(regWrData[EVT_W-1:0]),
    .flags(evtFlags),
    .mask(evtMask),
    .irq(dmaIrq)
  );

  // ****************************************
  // Data port
  // ****************************************
  // Write hands a byte to the transfer engine, read pops one from it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tdOut_q <= `HCS_REG_RST;
      tdWr_q <= 1'b0;
      tdRd_q <= 1'b0;
    end else begin
      tdWr_q <= regWrEn && regAddr == `HCS_OFF_TDATA;
      tdRd_q <= regRdEn && regAddr == `HCS_OFF_TDATA;
      if (regWrEn && regAddr == `HCS_OFF_TDATA) begin
        tdOut_q <= regWrData;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Unused and firmware-only offsets read as zero
  always_comb begin
    rdData_d = `HCS_REG_RST;
    if (inWindow(regAddr)) begin
      rdData_d = parMem_q[winIdx(regAddr)];
    end else begin
      unique case (regAddr)
        `HCS_OFF_CMD: rdData_d = {5'h00, cmdReg_q};
        // RULE_05: status shows processing state
        `HCS_OFF_STS: rdData_d = {5'h00, cmdIf.state};
        `HCS_OFF_XMODE: rdData_d = xMode_q;
        `HCS_OFF_SRC_H: rdData_d = {4'h0, srcHi_q};
        `HCS_OFF_SRC_M: rdData_d = srcMid_q;
        `HCS_OFF_SRC_L: rdData_d = srcLo_q;
        `HCS_OFF_DST_H: rdData_d = {7'h00, dstHi_q};
        `HCS_OFF_DST_M: rdData_d = dstMid_q;
        `HCS_OFF_DST_L: rdData_d = dstLo_q;
        `HCS_OFF_CNT_H: rdData_d = {5'h00, cntHi_q};
        `HCS_OFF_CNT_M: rdData_d = cntMid_q;
        `HCS_OFF_CNT_L: rdData_d = cntLo_q;
        `HCS_OFF_ICPU: rdData_d = {7'h00, icpu_q};
        `HCS_OFF_EMASK: rdData_d = {5'h00, evtMask};
        `HCS_OFF_EFLAG: rdData_d = {5'h00, evtFlags};
        `HCS_OFF_ROM: rdData_d = {5'h00, rom_q};
        `HCS_OFF_POL: rdData_d = {6'h00, pol_q};
        `HCS_OFF_RST: rdData_d = {6'h00, nbr_q, 1'b0};
        `HCS_OFF_TDATA: rdData_d = xferDataIn;
        default: rdData_d = `HCS_REG_RST;
      endcase
    end
  end

  // Read data held until the next read; valid is a one-cycle pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_q <= `HCS_REG_RST;
      rdValid_q <= 1'b0;
    end else begin
      rdValid_q <= regRdEn;
      if (regRdEn) begin
        rdData_q <= rdData_d;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdData = rdData_q;
  assign regRdValid = rdValid_q;
  assign cpuParData = cpuPar_q;
  assign transferMode = xMode_q;
  assign srcAddr = {srcHi_q, srcMid_q, srcLo_q};
  assign dstAddr = {dstHi_q, dstMid_q, dstLo_q};
  assign xferCount = {cntHi_q, cntMid_q, cntLo_q};
  assign icpuInt = icpu_q;
  assign romSelect = rom_q;
  assign isreqPol = pol_q[`HCS_POL_ISREQ_BIT];
  assign osvldPol = pol_q[`HCS_POL_OSVLD_BIT];
  assign cpuResetHold = nbr_q;
  assign xferDataOut = tdOut_q;
  assign xferDataWr = tdWr_q;
  assign xferDataRd = tdRd_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_sts_read;
    regRdEn && regAddr == `HCS_OFF_STS
      |=> regRdValid && regRdData == {5'h00, $past(cmdIf.state)};
  endproperty
  a_sts_read: assert property (p_sts_read) else $error("status read wrong"); // RULE_05
  sequence s_parWr;
    regWrEn && !regRdEn && regAddr == `HCS_OFF_PAR_LO;
  endsequence
  sequence s_parRd;
    regRdEn && !regWrEn && regAddr == `HCS_OFF_PAR_LO;
  endsequence
  property p_par_round;
    s_parWr ##1 s_parRd |=> regRdData == $past(regWrData, 2);
  endproperty
  a_par_round: assert property (p_par_round) else $error("parameter lost"); // RULE_10
endmodule
`default_nettype wire

// [common/hcs_cfg.svh]
`ifndef HCS_CFG_SVH
`define HCS_CFG_SVH
// ****************************************
// Register offsets
// ****************************************
`define HCS_OFF_CMD 6'h00
`define HCS_OFF_STS 6'h01
`define HCS_OFF_PAR_LO 6'h02
`define HCS_OFF_PAR_HI 6'h1F
`define HCS_OFF_XMODE 6'h20
`define HCS_OFF_SRC_H 6'h21
`define HCS_OFF_SRC_M 6'h22
`define HCS_OFF_SRC_L 6'h23
`define HCS_OFF_DST_H 6'h24
`define HCS_OFF_DST_M 6'h25
`define HCS_OFF_DST_L 6'h26
`define HCS_OFF_CNT_H 6'h27
`define HCS_OFF_CNT_M 6'h28
`define HCS_OFF_CNT_L 6'h29
`define HCS_OFF_ICPU 6'h2A
`define HCS_OFF_EMASK 6'h2B
`define HCS_OFF_EFLAG 6'h30
`define HCS_OFF_ROM 6'h35
`define HCS_OFF_POL 6'h36
`define HCS_OFF_RST 6'h3E
`define HCS_OFF_TDATA 6'h3F
// ****************************************
// Field widths, positions and codes
// ****************************************
`define HCS_CMD_W 3
`define HCS_XMODE_MASK 8'hFB
`define HCS_SRC_H_W 4
`define HCS_CNT_H_W 3
`define HCS_ROM_W 3
`define HCS_EVT_W 3
`define HCS_POL_W 2
`define HCS_POL_ISREQ_BIT 1
`define HCS_POL_OSVLD_BIT 0
`define HCS_RST_NBR_BIT 1
`define HCS_RST_ALL_BIT 0
`define HCS_CMD_STBY 3'h1
`define HCS_CMD_START 3'h3
`define HCS_ST_INIT_CODE 3'h0
`define HCS_ST_STBY_CODE 3'h1
`define HCS_ST_ENC_CODE 3'h3
`define HCS_REG_RST 8'h00
`endif

// [common/hcs_pkg.sv]
`include "hcs_cfg.svh"
`default_nettype none
package hcs_pkg;
  // Processing state, coded as the status register reports it
  typedef enum logic [2:0] {
    HCS_ST_INIT = `HCS_ST_INIT_CODE,
    HCS_ST_STBY = `HCS_ST_STBY_CODE,
    HCS_ST_ENC = `HCS_ST_ENC_CODE
  } hcs_state_e;
endpackage
`default_nettype wire

// [common/hcs_cmd_if.sv]
`include "hcs_cfg.svh"
`default_nettype none
interface hcs_cmd_if;
  import hcs_pkg::*;
  logic cmdWrite;
  logic [`HCS_CMD_W-1:0] cmdCode;
  logic softClr;
  hcs_state_e state;
  logic startPulse;
  modport regs (output cmdWrite, output cmdCode, output softClr, input state, input startPulse);
  modport fsm (input cmdWrite, input cmdCode, input softClr, output state, output startPulse);
endinterface
`default_nettype wire

// [design/hcs_cmd_fsm.sv]
`include "hcs_cfg.svh"
`default_nettype none
module hcs_cmd_fsm
  import hcs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  hcs_cmd_if.fsm cmdIf
);
  hcs_state_e state_q;
  hcs_state_e state_d;
  logic startPulse_q;

  // Next state from the command just written; no write means hold
  always_comb begin
    // RULE_06: illegal holds state
    // RULE_12: reserved codes ignored
    state_d = state_q;
    if (cmdIf.cmdWrite) begin
      // RULE_03: per-state acceptance
      unique case (state_q)
        // RULE_07: standby from initial
        HCS_ST_INIT: if (cmdIf.cmdCode == `HCS_CMD_STBY) state_d = HCS_ST_STBY;
        // RULE_08: start from standby
        HCS_ST_STBY: if (cmdIf.cmdCode == `HCS_CMD_START) state_d = HCS_ST_ENC;
        // RULE_13: stop returns to standby
        HCS_ST_ENC: if (cmdIf.cmdCode == `HCS_CMD_STBY) state_d = HCS_ST_STBY;
        default: state_d = HCS_ST_INIT;
      endcase
    end
  end

  // State register; soft reset wins over any command
  // RULE_04: move to commanded state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= HCS_ST_INIT;
    end else if (cmdIf.softClr) begin
      state_q <= HCS_ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  // One pulse when encoding begins, so the core fetches parameters once
  // RULE_11: start pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      startPulse_q <= 1'b0;
    end else begin
      startPulse_q <= !cmdIf.softClr && state_q == HCS_ST_STBY && state_d == HCS_ST_ENC;
    end
  end

  assign cmdIf.state = state_q;
  assign cmdIf.startPulse = startPulse_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_stbyCmd;
    cmdIf.cmdWrite && cmdIf.cmdCode == `HCS_CMD_STBY && !cmdIf.softClr;
  endsequence
  sequence s_startCmd;
    cmdIf.cmdWrite && cmdIf.cmdCode == `HCS_CMD_START && !cmdIf.softClr;
  endsequence
  property p_init_stby;
    (state_q == HCS_ST_INIT) and s_stbyCmd |=> state_q == HCS_ST_STBY;
  endproperty
  a_init_stby: assert property (p_init_stby) else $error("standby not taken"); // RULE_07
  property p_stby_enc;
    (state_q == HCS_ST_STBY) and s_startCmd |=> state_q == HCS_ST_ENC;
  endproperty
  a_stby_enc: assert property (p_stby_enc) else $error("start not taken"); // RULE_08
  property p_enc_stop;
    (state_q == HCS_ST_ENC) and s_stbyCmd |=> state_q == HCS_ST_STBY;
  endproperty
  a_enc_stop: assert property (p_enc_stop) else $error("stop not taken"); // RULE_13
  property p_reserved_hold;
    cmdIf.cmdWrite && !cmdIf.softClr && cmdIf.cmdCode != `HCS_CMD_STBY
      && cmdIf.cmdCode != `HCS_CMD_START |=> $stable(state_q);
  endproperty
  a_reserved_hold: assert property (p_reserved_hold) else $error("reserved moved"); // RULE_12
  property p_illegal_hold;
    (state_q != HCS_ST_STBY) and s_startCmd |=> $stable(state_q);
  endproperty
  a_illegal_hold: assert property (p_illegal_hold) else $error("illegal start"); // RULE_06
  property p_start_pulse;
    (state_q == HCS_ST_STBY) and s_startCmd |=> startPulse_q ##1 !startPulse_q;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("no start pulse"); // RULE_11
endmodule
`default_nettype wire

// [design/hcs_evt_flags.sv]
`include "hcs_cfg.svh"
`default_nettype none
module hcs_evt_flags
  import hcs_pkg::*;
#(
  parameter int EVT_W = `HCS_EVT_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic softClr,
  input wire logic [EVT_W-1:0] evtSet,
  input wire logic flagWr,
  input wire logic maskWr,
  input wire logic [EVT_W-1:0] wrData,
  output logic [EVT_W-1:0] flags,
  output logic [EVT_W-1:0] mask,
  output logic irq
);
  logic [EVT_W-1:0] flags_q;
  logic [EVT_W-1:0] mask_q;
  logic irq_q;

  // Sticky flags; writing 0 clears a bit, a same-cycle event still sets it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      flags_q <= '0;
    end else if (softClr) begin
      flags_q <= evtSet;
    end else begin
      flags_q <= (flagWr ? (flags_q & wrData) : flags_q) | evtSet;
    end
  end

  // Mask bit set to 1 keeps the event off the request line
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_q <= '0;
    end else if (softClr) begin
      mask_q <= '0;
    end else if (maskWr) begin
      mask_q <= wrData;
    end
  end

  // Registered request, one cycle behind the flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & ~mask_q);
    end
  end

  assign flags = flags_q;
  assign mask = mask_q;
  assign irq = irq_q;
endmodule
`default_nettype wire

// [testbench/hcs_host_model.sv]
`include "hcs_cfg.svh"
`default_nettype none
module hcs_host_model (
  input wire logic clock,
  output logic [5:0] regAddr,
  output logic regWrEn,
  output logic regRdEn,
  output logic [7:0] regWrData
);
  timeunit 1ns;
  timeprecision 100ps;
  // Quiet bus at time zero
  initial begin
    regAddr = 6'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regWrData = 8'h00;
  end
  // ****************************************
  // Bus cycles
  // ****************************************
  // commands only by register write
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    // Parked lines show the inverse so stale values never match
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // Write, then read the same offset at the very next edge
  task automatic wrRd(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // One-cycle read strobe, answer comes back on regRdValid
  task automatic rd(input logic [5:0] a);
    @(posedge clock);
    regAddr <= a;
    regRdEn <= 1'b1;
    @(posedge clock);
    regRdEn <= 1'b0;
    regAddr <= ~a;
  endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
`include "hcs_cfg.svh"
`default_nettype none
module testbench;
  import hcs_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock;
  logic rst;
  logic [5:0] regAddr;
  logic regWrEn;
  logic regRdEn;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic regRdValid;
  logic [5:0] cpuParAddr;
  logic [7:0] cpuParData;
  logic encodeRun;
  logic startPulse;
  logic [19:0] srcAddr;
  logic [7:0] transferMode;
  logic [16:0] dstAddr;
  logic [18:0] xferCount;
  logic [2:0] romSelect;
  logic icpuInt, isreqPol, osvldPol, cpuResetHold;
  logic [7:0] xferDataOut;
  logic xferDataWr, xferDataRd;
  logic [2:0] dmaEvtSet;
  logic dmaIrq;
  logic [7:0] xferDataIn;
  logic [7:0] expQ [$];
  logic [7:0] wd [64];
  logic [15:0] regTab [16] = '{16'h20FB, 16'h210F, 16'h22FF, 16'h23FF, 16'h2401, 16'h25FF,
    16'h26FF, 16'h2707, 16'h28FF, 16'h29FF, 16'h2A01, 16'h2B07, 16'h3507, 16'h3603,
    16'h2C00, 16'h3A00};
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  int unsigned rnd;
  // Free-running 40 MHz clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  hcs_host_model host_i (.clock(clock), .regAddr(regAddr), .regWrEn(regWrEn),
    .regRdEn(regRdEn), .regWrData(regWrData));
  hcs_host_regs hcs_host_regs_i (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData), .regRdData(regRdData),
    .regRdValid(regRdValid), .cpuParAddr(cpuParAddr), .cpuParData(cpuParData),
    .encodeRun(encodeRun), .startPulse(startPulse), .transferMode(transferMode),
    .srcAddr(srcAddr), .dstAddr(dstAddr), .xferCount(xferCount), .icpuInt(icpuInt),
    .romSelect(romSelect), .isreqPol(isreqPol), .osvldPol(osvldPol),
    .cpuResetHold(cpuResetHold), .dmaEvtSet(dmaEvtSet), .dmaIrq(dmaIrq),
    .xferDataIn(xferDataIn), .xferDataOut(xferDataOut), .xferDataWr(xferDataWr),
    .xferDataRd(xferDataRd));
  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Note the answer first so the watcher never meets an empty queue
  task automatic expRd(input logic [5:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host_i.rd(a);
  endtask
  // Every code but the legal one must leave the state alone
  task automatic rejectAll(input logic [2:0] okCode, input logic [2:0] st);
    for (int c = 0; c < 8; c++) begin
      if (c[2:0] != okCode) begin
        host_i.wr(`HCS_OFF_CMD, {5'h00, c[2:0]});
        #1 check(startPulse, 0);
        expRd(`HCS_OFF_STS, {5'h00, st});
      end
    end
  endtask
  // Read answers compared in arrival order
  always @(posedge clock) begin
    if (regRdValid === 1'b1) begin
      if (expQ.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        check({24'h0, regRdData}, {24'h0, expQ.pop_front()});
      end
    end
  end
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst = 1'b1;
    cpuParAddr = 6'h00;
    dmaEvtSet = 3'h0;
    xferDataIn = 8'h00;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    rnd = $urandom(78458);
    expRd(`HCS_OFF_STS, 8'h00);
    expRd(`HCS_OFF_CMD, 8'h00);
    $display("test reset done");
    rejectAll(`HCS_CMD_STBY, `HCS_ST_INIT_CODE);
    host_i.wr(`HCS_OFF_CMD, 8'h01);
    #1 check(encodeRun, 0);
    expRd(`HCS_OFF_STS, 8'h01);
    expRd(`HCS_OFF_CMD, 8'h01);
    rejectAll(`HCS_CMD_START, `HCS_ST_STBY_CODE);
    host_i.wr(`HCS_OFF_CMD, 8'h03);
    #1 check(startPulse, 1);
    check(encodeRun, 1);
    @(posedge clock);
    #1 check(startPulse, 0);
    check(encodeRun, 1);
    expRd(`HCS_OFF_STS, 8'h03);
    rejectAll(`HCS_CMD_STBY, `HCS_ST_ENC_CODE);
    host_i.wr(`HCS_OFF_CMD, 8'h01);
    #1 check(encodeRun, 0);
    expRd(`HCS_OFF_STS, 8'h01);
    $display("test command states done");
    for (int a = 2; a < 32; a++) begin
      wd[a] = 8'($urandom);
      host_i.wr(a[5:0], wd[a]);
    end
    for (int a = 2; a < 32; a++) begin
      expRd(a[5:0], wd[a]);
      cpuParAddr <= a[5:0];
      @(posedge clock);
      #1 check(cpuParData, wd[a]);
    end
    cpuParAddr <= `HCS_OFF_XMODE;
    @(posedge clock);
    #1 check(cpuParData, 0);
    // Read straight after write must see the new byte
    wd[2] = 8'($urandom);
    expQ.push_back(wd[2]);
    host_i.wrRd(`HCS_OFF_PAR_LO, wd[2]);
    $display("test parameter window done");
    foreach (regTab[i]) begin
      wd[regTab[i][13:8]] = 8'($urandom);
      host_i.wr(regTab[i][13:8], wd[regTab[i][13:8]]);
      expRd(regTab[i][13:8], wd[regTab[i][13:8]] & regTab[i][7:0]);
    end
    check(srcAddr, {wd[6'h21][3:0], wd[6'h22], wd[6'h23]});
    check(dstAddr, {wd[6'h24][0], wd[6'h25], wd[6'h26]});
    check(xferCount, {wd[6'h27][2:0], wd[6'h28], wd[6'h29]});
    check(transferMode, wd[6'h20] & `HCS_XMODE_MASK);
    check({romSelect, icpuInt, isreqPol, osvldPol},
      {wd[6'h35][2:0], wd[6'h2A][0], wd[6'h36][1:0]});
    // Data port: write strobe and byte, then read strobe
    wd[6'h3F] = 8'($urandom);
    host_i.wr(`HCS_OFF_TDATA, wd[6'h3F]);
    #1 check({xferDataWr, xferDataOut}, {1'h1, wd[6'h3F]});
    @(posedge clock);
    xferDataIn <= 8'($urandom);
    #1 expRd(`HCS_OFF_TDATA, xferDataIn);
    #1 check({xferDataRd, xferDataWr}, 2'h2);
    $display("test register map done");
    host_i.wr(`HCS_OFF_CMD, 8'h03);
    host_i.wr(`HCS_OFF_RST, 8'h02);
    #1 check(cpuResetHold, 1);
    host_i.wr(`HCS_OFF_RST, 8'h01);
    #1 check(encodeRun, 0);
    check(cpuResetHold, 0);
    expRd(`HCS_OFF_STS, 8'h00);
    expRd(`HCS_OFF_RST, 8'h00);
    expRd(`HCS_OFF_EMASK, 8'h00);
    host_i.wr(`HCS_OFF_STS, 8'hFF);
    expRd(`HCS_OFF_STS, 8'h00);
    $display("test soft reset done");
    @(posedge clock);
    dmaEvtSet <= 3'h1;
    @(posedge clock);
    dmaEvtSet <= 3'h0;
    @(posedge clock);
    #1 check(dmaIrq, 1);
    expRd(`HCS_OFF_EFLAG, 8'h01);
    host_i.wr(`HCS_OFF_EFLAG, 8'h00);
    expRd(`HCS_OFF_EFLAG, 8'h00);
    repeat (3) @(posedge clock);
    #1 check(dmaIrq, 0);
    check(expQ.size(), 0);
    $display("test event flags done");
    report_and_stop();
  end
endmodule
`default_nettype wire
